// ==== hdl/him_cfg.svh ====
// Constants of the host interface mode selection block
`ifndef HIM_CFG_SVH
`define HIM_CFG_SVH

// ----------------------------------------------------------------
// System clock
// ----------------------------------------------------------------
`define HIM_SYS_CLK_PER_NS 5

// ----------------------------------------------------------------
// Serial word and shift counter
// ----------------------------------------------------------------
`define HIM_SPI_WORD_BITS 24
`define HIM_SPI_CNT_W 5
`define HIM_SPI_CNT_LAST 5'h17
`define HIM_SPI_CNT_ZERO 5'h00

// ----------------------------------------------------------------
// Link rates
// ----------------------------------------------------------------
`define HIM_SPI_MAX_KHZ 30000
`define HIM_I2C_STD_KHZ 100
`define HIM_I2C_FAST_KHZ 400
// Shortest clock period in system cycles, rounded up
`define HIM_SPI_MIN_PER_CYC \
    ((1000000 + `HIM_SPI_MAX_KHZ * `HIM_SYS_CLK_PER_NS - 1) / \
    (`HIM_SPI_MAX_KHZ * `HIM_SYS_CLK_PER_NS))

// ----------------------------------------------------------------
// Pin synchronisers
// ----------------------------------------------------------------
// Reset levels of the synchronised pins; only the frame pin idles high
`define HIM_PIN_IDLE 6'h20

// ----------------------------------------------------------------
// Strap sampling
// ----------------------------------------------------------------
`define HIM_STRAP_WAIT_W 2
`define HIM_STRAP_WAIT_LAST 2'h2
`define HIM_STRAP_FIFO_RST 1'h0

`endif

// ==== hdl/him_pkg.sv ====
// Types of the host interface mode selection block
`default_nettype none

package him_pkg;
    typedef enum logic [1:0] {
        HIM_MODE_PARALLEL,
        HIM_MODE_SPI,
        HIM_MODE_I2C
    } him_mode_t;
endpackage : him_pkg

`default_nettype wire

// ==== hdl/him_spi_if.sv ====
// Signals between the mode selector and the serial shifter
`default_nettype none
`include "him_cfg.svh"

interface him_spi_if;
    logic enable;
    logic frame_active;
    logic sclk_rise;
    logic sclk_fall;
    logic din;
    logic [`HIM_SPI_WORD_BITS-1:0] readback_word;
    logic [`HIM_SPI_WORD_BITS-1:0] word;
    logic word_valid;
    logic readback_bit;

    modport ctrl (
        output enable, frame_active, sclk_rise, sclk_fall, din, readback_word,
        input word, word_valid, readback_bit
    );
    modport shifter (
        input enable, frame_active, sclk_rise, sclk_fall, din, readback_word,
        output word, word_valid, readback_bit
    );
endinterface : him_spi_if

`default_nettype wire

// ==== hdl/him_spi_shifter.sv ====
// Serial shift register with readback launch
`default_nettype none
`include "him_cfg.svh"

module him_spi_shifter (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Link to selector
    him_spi_if.shifter spi
);
    logic [`HIM_SPI_WORD_BITS-1:0] shift_in;
    logic [`HIM_SPI_WORD_BITS-1:0] shift_out;
    logic [`HIM_SPI_CNT_W-1:0] bit_cnt;
    logic frame_prev;
    logic frame_start;

    assign frame_start = spi.frame_active && !frame_prev;

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            frame_prev <= 1'h0;
        end else begin
            frame_prev <= spi.frame_active;
        end
    end

    // ----------------------------------------------------------------
    // Capture side
    // ----------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            shift_in <= '0;
            bit_cnt <= `HIM_SPI_CNT_ZERO;
            spi.word <= '0;
            spi.word_valid <= 1'h0;
        end else begin
            spi.word_valid <= 1'h0;
            if (!spi.enable || !spi.frame_active) begin
                bit_cnt <= `HIM_SPI_CNT_ZERO;
            end else if (spi.sclk_fall) begin
                shift_in <= {shift_in[`HIM_SPI_WORD_BITS-2:0], spi.din};
                if (bit_cnt == `HIM_SPI_CNT_LAST) begin
                    spi.word <= {shift_in[`HIM_SPI_WORD_BITS-2:0], spi.din};
                    spi.word_valid <= 1'h1;
                    bit_cnt <= `HIM_SPI_CNT_ZERO;
                end else begin
                    bit_cnt <= bit_cnt + 5'h01;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Readback side
    // ----------------------------------------------------------------
    // First bit is presented at frame start, the rest follow rising edges
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            shift_out <= '0;
            spi.readback_bit <= 1'h0;
        end else if (!spi.enable) begin
            spi.readback_bit <= 1'h0;
        end else if (frame_start) begin
            shift_out <= {spi.readback_word[`HIM_SPI_WORD_BITS-2:0], 1'h0};
            spi.readback_bit <= spi.readback_word[`HIM_SPI_WORD_BITS-1];
        end else if (spi.frame_active && spi.sclk_rise) begin
            shift_out <= {shift_out[`HIM_SPI_WORD_BITS-2:0], 1'h0};
            spi.readback_bit <= shift_out[`HIM_SPI_WORD_BITS-1];
        end
    end
endmodule : him_spi_shifter

`default_nettype wire

// ==== hdl/him_host_if_select.sv ====
// Host port mode selection: parallel, four-wire serial or two-wire bus
`default_nettype none
`include "him_cfg.svh"

module him_host_if_select
    import him_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Mode pins
    input wire logic i_serial_or_parallel_select,
    input wire logic i_fifo_enable_strap,
    // Shared pins
    input wire logic i_protocol_select_or_bit11,
    input wire logic i_clock_or_bit12,
    input wire logic i_serial_in_or_bit13,
    output logic o_serial_in_or_bit13,
    output logic o_serial_in_or_bit13_oe,
    input wire logic i_frame_n,
    output logic o_serial_readback_out,
    // Core events
    input wire logic i_clear_event,
    input wire logic i_reset_event,
    input wire logic [`HIM_SPI_WORD_BITS-1:0] i_readback_word,
    input wire logic i_i2c_sda_pull_low,
    // Results to core
    output him_mode_t o_mode,
    output logic o_fifo_active,
    output logic [2:0] o_parallel_bits,
    output logic [`HIM_SPI_WORD_BITS-1:0] o_spi_word,
    output logic o_spi_word_valid,
    output logic o_i2c_scl,
    output logic o_i2c_sda
);
    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    localparam int NPIN = 6;
    // Frame pin resets high, its idle level, so no false frame edge follows reset
    localparam logic [NPIN-1:0] PIN_IDLE = `HIM_PIN_IDLE;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_meta;
    logic [NPIN-1:0] pin_sync;

    assign pin_raw = {i_frame_n, i_fifo_enable_strap, i_serial_or_parallel_select,
        i_serial_in_or_bit13, i_clock_or_bit12, i_protocol_select_or_bit11};

    // Each pin crosses into the system clock through two flops
    generate
        for (genvar g = 0; g < NPIN; g++) begin : g_sync
            always_ff @(posedge i_sys_clk) begin
                if (i_rst) begin
                    pin_meta[g] <= PIN_IDLE[g];
                    pin_sync[g] <= PIN_IDLE[g];
                end else begin
                    pin_meta[g] <= pin_raw[g];
                    pin_sync[g] <= pin_meta[g];
                end
            end
        end
    endgenerate

    logic bit11_s;
    logic bit12_s;
    logic bit13_s;
    logic serial_sel_s;
    logic strap_s;
    logic frame_n_s;

    assign bit11_s = pin_sync[0];
    assign bit12_s = pin_sync[1];
    assign bit13_s = pin_sync[2];
    assign serial_sel_s = pin_sync[3];
    assign strap_s = pin_sync[4];
    assign frame_n_s = pin_sync[5];

    // ----------------------------------------------------------------
    // Mode decode
    // ----------------------------------------------------------------
    function automatic him_mode_t decode_mode(input logic serial_sel, input logic proto);
        him_mode_t m;
        m = HIM_MODE_PARALLEL;
        if (!serial_sel) begin
            m = HIM_MODE_PARALLEL;
        end else if (!proto) begin
            m = HIM_MODE_SPI;
        end else begin
            m = HIM_MODE_I2C;
        end
        return m;
    endfunction : decode_mode

    him_mode_t next_mode;
    assign next_mode = decode_mode(serial_sel_s, bit11_s);

    // Mode enables shared by every output section
    logic par_en;
    logic spi_en;
    logic i2c_en;

    assign par_en = (next_mode == HIM_MODE_PARALLEL);
    assign spi_en = (next_mode == HIM_MODE_SPI);
    assign i2c_en = (next_mode == HIM_MODE_I2C);

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_mode <= HIM_MODE_PARALLEL;
        end else begin
            o_mode <= next_mode;
        end
    end

    // ----------------------------------------------------------------
    // FIFO strap
    // ----------------------------------------------------------------
    // Waits for the synchroniser to fill before the first sample
    logic [`HIM_STRAP_WAIT_W-1:0] strap_wait;
    logic strap_pending;
    logic strap_latched;

    logic strap_event;
    logic strap_sample;

    // Clear and reset restart the wait over completion, but a sample due in the same cycle is still latched
    assign strap_event = i_clear_event || i_reset_event;
    assign strap_sample = strap_pending && (strap_wait == `HIM_STRAP_WAIT_LAST);

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            strap_wait <= '0;
        end else if (strap_event) begin
            strap_wait <= '0;
        end else if (strap_pending && !strap_sample) begin
            strap_wait <= strap_wait + 2'h1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            strap_pending <= 1'h1;
        end else if (strap_event) begin
            strap_pending <= 1'h1;
        end else if (strap_sample) begin
            strap_pending <= 1'h0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            strap_latched <= `HIM_STRAP_FIFO_RST;
        end else if (strap_sample) begin
            strap_latched <= strap_s;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_fifo_active <= 1'h0;
        end else begin
            o_fifo_active <= strap_latched && par_en;
        end
    end

    // ----------------------------------------------------------------
    // Parallel data bits
    // ----------------------------------------------------------------
    // shared pins as bits 11-13
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_parallel_bits <= 3'h0;
        end else if (par_en) begin
            o_parallel_bits <= {bit13_s, bit12_s, bit11_s};
        end else begin
            o_parallel_bits <= 3'h0;
        end
    end

    // ----------------------------------------------------------------
    // Serial clock edges
    // ----------------------------------------------------------------
    // Edges come from the synchronised copy only; clocks above the
    // guaranteed rate alias, which the sampling rate leaves margin for
    logic sclk_prev;

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            sclk_prev <= 1'h0;
        end else begin
            sclk_prev <= bit12_s;
        end
    end

    him_spi_if spi ();

    assign spi.enable = spi_en;
    assign spi.frame_active = !frame_n_s;
    assign spi.sclk_fall = sclk_prev && !bit12_s;
    assign spi.sclk_rise = !sclk_prev && bit12_s;
    assign spi.din = bit13_s;
    assign spi.readback_word = i_readback_word;

    him_spi_shifter u_shifter (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .spi(spi.shifter)
    );

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_spi_word_valid <= 1'h0;
        end else begin
            o_spi_word_valid <= spi.word_valid;
        end
    end

    // Word holds between pulses so the core may take it late
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_spi_word <= '0;
        end else if (spi.word_valid) begin
            o_spi_word <= spi.word;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_serial_readback_out <= 1'h0;
        end else begin
            o_serial_readback_out <= spi.readback_bit;
        end
    end

    // ----------------------------------------------------------------
    // Two-wire bus lines
    // ----------------------------------------------------------------
    // Lines idle high outside the bus mode so the engine sees no false start
    // lines passed at any bus rate
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_i2c_scl <= 1'h1;
        end else if (i2c_en) begin
            o_i2c_scl <= bit12_s;
        end else begin
            o_i2c_scl <= 1'h1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_i2c_sda <= 1'h1;
        end else if (i2c_en) begin
            o_i2c_sda <= bit13_s;
        end else begin
            o_i2c_sda <= 1'h1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_serial_in_or_bit13 <= 1'h0;
        end else begin
            o_serial_in_or_bit13 <= 1'h0;
        end
    end

    // Enable is gated by mode, so a stale pull request never drives a data bit
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_serial_in_or_bit13_oe <= 1'h0;
        end else begin
            o_serial_in_or_bit13_oe <= i2c_en && i_i2c_sda_pull_low;
        end
    end
endmodule : him_host_if_select

`default_nettype wire

// ==== testbench/him_host_if_select_monitor.sv ====
// Checker of host mode selection
`default_nettype none
module him_host_if_select_monitor
    import him_pkg::*;
(
    // Clock, reset and pins
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_serial_or_parallel_select,
    input wire logic i_protocol_select_or_bit11,
    input wire logic i_clock_or_bit12,
    input wire logic i_serial_in_or_bit13,
    input wire logic i_i2c_sda_pull_low,
    // Outputs watched
    input wire logic o_serial_in_or_bit13,
    input wire logic o_serial_in_or_bit13_oe,
    input wire him_mode_t o_mode,
    input wire logic o_fifo_active,
    input wire logic [2:0] o_parallel_bits,
    input wire logic o_spi_word_valid,
    input wire logic o_i2c_scl
);
    timeunit 1ns;
    timeprecision 100ps;
    wire logic ser = i_serial_or_parallel_select;
    wire logic sel = i_protocol_select_or_bit11;
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);
    // Five cycles: two sync, one register, margin for reset release
    spi_mode_a: assert property ((ser && !sel)[*5] |-> o_mode == HIM_MODE_SPI)
        else $error("spi mode missing");
    i2c_mode_a: assert property ((ser && sel)[*5] |-> o_mode == HIM_MODE_I2C)
        else $error("i2c mode missing");
    par_bits_a: assert property (!ser[*5] |-> o_mode == HIM_MODE_PARALLEL &&
        o_parallel_bits == $past({i_serial_in_or_bit13, i_clock_or_bit12, sel}, 3))
        else $error("parallel bits wrong");
    bits_zero_a: assert property (o_mode != HIM_MODE_PARALLEL |-> !o_parallel_bits)
        else $error("parallel bits outside parallel mode");
    fifo_par_a: assert property (o_fifo_active |-> o_mode == HIM_MODE_PARALLEL)
        else $error("fifo active outside parallel mode");
    drive_low_a: assert property (o_serial_in_or_bit13_oe |->
        o_mode == HIM_MODE_I2C && !o_serial_in_or_bit13) else $error("data pin misdriven");
    oe_pull_a: assert property ((ser && sel)[*5] |->
        o_serial_in_or_bit13_oe == $past(i_i2c_sda_pull_low)) else $error("pull not followed");
    scl_pass_a: assert property ((ser && sel)[*5] |->
        o_i2c_scl == $past(i_clock_or_bit12, 3)) else $error("bus clock not passed");
    valid_pulse_a: assert property (o_spi_word_valid |=> !o_spi_word_valid)
        else $error("word valid too long");
    cover property (o_spi_word_valid);
    cover property (o_fifo_active);
    cover property (o_serial_in_or_bit13_oe);
endmodule : him_host_if_select_monitor

bind him_host_if_select him_host_if_select_monitor him_host_if_select_monitor_inst (
    .i_sys_clk, .i_rst, .i_serial_or_parallel_select, .i_protocol_select_or_bit11,
    .i_clock_or_bit12, .i_serial_in_or_bit13, .i_i2c_sda_pull_low, .o_serial_in_or_bit13,
    .o_serial_in_or_bit13_oe, .o_mode, .o_fifo_active, .o_parallel_bits, .o_spi_word_valid,
    .o_i2c_scl
);
`default_nettype wire

// ==== testbench/him_host_model.sv ====
// Host controller model driving the shared pins
`default_nettype none
module him_host_model (
    // Pins toward the device
    output logic o_sel,
    output logic o_strap,
    output logic o_b11,
    output logic o_b12,
    output wire logic o_b13,
    output logic o_frame_n,
    // Pins from the device
    input wire logic i_readback,
    input wire logic i_dev_pull
);
    timeunit 1ns;
    timeprecision 100ps;
    logic din;
    assign o_b13 = (o_sel && o_b11) ? (din && !i_dev_pull) : din;
    initial begin
        o_sel = 1'h0;
        o_strap = 1'h0;
        o_b11 = 1'h0;
        o_b12 = 1'h1;
        o_frame_n = 1'h1;
        din = 1'h0;
    end
    task automatic set_pins(input logic s, f, p, c, d);
        o_sel = s;
        o_strap = f && !s;
        o_b11 = p;
        o_b12 = c;
        din = d;
    endtask : set_pins
    // Clock idles high and stands still outside frames
    task automatic spi_word(input logic [23:0] w, output logic [23:0] rb);
        o_frame_n = 1'h0;
        #30;
        for (int i = 23; i >= 0; i--) begin
            din = w[i];
            #24;
            rb[i] = i_readback;
            o_b12 = 1'h0;
            #24;
            o_b12 = 1'h1;
        end
        #30;
        o_frame_n = 1'h1;
        din = !din;
    endtask : spi_word
endmodule : him_host_model
`default_nettype wire

// ==== testbench/him_host_if_select_test.sv ====
// Self-checking bench of the host mode selector
`default_nettype none
`include "him_cfg.svh"
module him_host_if_select_test
    import him_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_sys_clk, i_rst, i_serial_or_parallel_select, i_fifo_enable_strap;
    logic i_protocol_select_or_bit11, i_clock_or_bit12, i_serial_in_or_bit13, i_frame_n;
    logic i_clear_event, i_reset_event, i_i2c_sda_pull_low;
    logic [`HIM_SPI_WORD_BITS-1:0] i_readback_word, o_spi_word;
    logic o_serial_in_or_bit13, o_serial_in_or_bit13_oe, o_serial_readback_out;
    logic o_fifo_active, o_spi_word_valid, o_i2c_scl, o_i2c_sda;
    logic [2:0] o_parallel_bits;
    him_mode_t o_mode;
    int n_errors = 0;
    int checks_done = 0;
    int n_valid = 0;
    him_host_if_select him_host_if_select_inst (.i_sys_clk, .i_rst,
        .i_serial_or_parallel_select, .i_fifo_enable_strap, .i_protocol_select_or_bit11,
        .i_clock_or_bit12, .i_serial_in_or_bit13, .o_serial_in_or_bit13,
        .o_serial_in_or_bit13_oe, .i_frame_n, .o_serial_readback_out, .i_clear_event,
        .i_reset_event, .i_readback_word, .i_i2c_sda_pull_low, .o_mode, .o_fifo_active,
        .o_parallel_bits, .o_spi_word, .o_spi_word_valid, .o_i2c_scl, .o_i2c_sda);
    him_host_model him_host_model_inst (.o_sel(i_serial_or_parallel_select),
        .o_strap(i_fifo_enable_strap), .o_b11(i_protocol_select_or_bit11),
        .o_b12(i_clock_or_bit12), .o_b13(i_serial_in_or_bit13), .o_frame_n(i_frame_n),
        .i_readback(o_serial_readback_out), .i_dev_pull(o_serial_in_or_bit13_oe));
    initial begin
        i_sys_clk = 1'h0;
        forever #2.5 i_sys_clk = ~i_sys_clk;
    end
    always @(posedge i_sys_clk) begin
        if (o_spi_word_valid === 1'h1) begin
            n_valid <= n_valid + 1;
        end
    end
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_of_test();
        if (n_errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test
    // Pins settle through sync and register in three cycles
    task automatic pins(input logic s, f, p, c, d);
        @(negedge i_sys_clk);
        him_host_model_inst.set_pins(s, f, p, c, d);
        repeat (6) @(negedge i_sys_clk);
    endtask : pins
    task automatic pulse(input logic clr);
        @(negedge i_sys_clk);
        i_clear_event = clr;
        i_reset_event = !clr;
        @(negedge i_sys_clk);
        i_clear_event = 1'h0;
        i_reset_event = 1'h0;
        repeat (8) @(negedge i_sys_clk);
    endtask : pulse
    task automatic t_parallel();
        pins(1'h0, 1'h1, 1'h1, 1'h0, 1'h1);
        check("mode", 24'(o_mode), 24'(HIM_MODE_PARALLEL));
        check("bits", 24'(o_parallel_bits), 24'h5);
        check("fifo early", 24'(o_fifo_active), 24'h0);
        pulse(1'h1);
        check("fifo", 24'(o_fifo_active), 24'h1);
        pins(1'h0, 1'h0, 1'h0, 1'h1, 1'h0);
        check("bits", 24'(o_parallel_bits), 24'h2);
        check("fifo held", 24'(o_fifo_active), 24'h1);
        pulse(1'h0);
        check("fifo reset", 24'(o_fifo_active), 24'h0);
        pins(1'h0, 1'h1, 1'h0, 1'h1, 1'h0);
        pulse(1'h1);
    endtask : t_parallel
    task automatic t_power_up();
        @(negedge i_sys_clk);
        i_rst = 1'h1;
        repeat (12) @(negedge i_sys_clk);
        check("fifo in reset", 24'(o_fifo_active), 24'h0);
        i_rst = 1'h0;
        @(negedge i_sys_clk);
        check("mode after reset", 24'(o_mode), 24'(HIM_MODE_PARALLEL));
        repeat (7) @(negedge i_sys_clk);
        check("fifo power-up", 24'(o_fifo_active), 24'h1);
    endtask : t_power_up
    task automatic t_spi();
        logic [23:0] w [2] = '{24'hA5C3E1, 24'h5A3C1E};
        logic [23:0] rb;
        int v0;
        pins(1'h1, 1'h1, 1'h0, 1'h1, 1'h0);
        check("mode", 24'(o_mode), 24'(HIM_MODE_SPI));
        check("fifo", 24'(o_fifo_active), 24'h0);
        pulse(1'h1);
        check("fifo clr", 24'(o_fifo_active), 24'h0);
        pins(1'h1, 1'h0, 1'h0, 1'h1, 1'h0);
        v0 = n_valid;
        for (int i = 0; i < 2; i++) begin
            @(negedge i_sys_clk);
            i_readback_word = ~w[i];
            him_host_model_inst.spi_word(w[i], rb);
            repeat (4) @(negedge i_sys_clk);
            check("word", o_spi_word, w[i]);
            check("readback", rb, ~w[i]);
        end
        check("valid", 24'(n_valid - v0), 24'h2);
    endtask : t_spi
    task automatic t_i2c();
        int h [2] = '{1000, 250};
        pins(1'h1, 1'h0, 1'h1, 1'h1, 1'h1);
        check("mode", 24'(o_mode), 24'(HIM_MODE_I2C));
        for (int j = 0; j < 2; j++) begin
            for (int v = 0; v < 2; v++) begin
                pins(1'h1, 1'h0, 1'h1, v[0], 1'h1);
                repeat (h[j]) @(negedge i_sys_clk);
                check("scl", 24'(o_i2c_scl), 24'(v[0]));
            end
        end
        check("sda free", 24'(o_i2c_sda), 24'h1);
        i_i2c_sda_pull_low = 1'h1;
        repeat (8) @(negedge i_sys_clk);
        check("oe", 24'(o_serial_in_or_bit13_oe), 24'h1);
        check("drive", 24'(o_serial_in_or_bit13), 24'h0);
        check("sda low", 24'(o_i2c_sda), 24'h0);
        pins(1'h1, 1'h0, 1'h0, 1'h1, 1'h1);
        check("oe spi", 24'(o_serial_in_or_bit13_oe), 24'h0);
        i_i2c_sda_pull_low = 1'h0;
    endtask : t_i2c
    initial begin
        i_rst = 1'h1;
        i_clear_event = 1'h0;
        i_reset_event = 1'h0;
        i_readback_word = 24'h000000;
        i_i2c_sda_pull_low = 1'h0;
        repeat (12) @(negedge i_sys_clk);
        i_rst = 1'h0;
        repeat (6) @(negedge i_sys_clk);
        t_parallel();
        t_power_up();
        t_spi();
        t_i2c();
        end_of_test();
    end
endmodule : him_host_if_select_test
`default_nettype wire
